// [rtl/ltrpi_pkg.sv]
// Package: constants and types for the logic tile routing port interface
package ltrpi_pkg;
    // Routing and datapath sizes
    localparam int ROUTE_W = 96;
    localparam int IDX_W = 7;
    localparam int NCTRL = 8;
    localparam int DP_IN = 6;
    localparam int DP_OUT = 6;
    localparam int DP_COND = 8;
    localparam int DP_SOUT = 2;
    localparam int DP_SRC = 10;
    localparam int DP_SEL_W = 4;
    localparam int NSUB = 4;
    localparam int NREQ = 4;
    localparam int PORT_W = 8;
    localparam int NOE = 4;
    localparam int NDRV = 4;

    // Subcomponent slots for clock control
    localparam int SUB_PLD0 = 0;
    localparam int SUB_PLD1 = 1;
    localparam int SUB_DP = 2;
    localparam int SUB_SC = 3;

    // Port routes taken from the tile routing
    localparam int PORT_OUT_LSB = 0;
    localparam int PORT_DRV_LSB = 8;
    localparam int PORT_OE_LSB = 12;

    // APB byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_STMODE = 8'h08;
    localparam logic [7:0] ADDR_CFG0 = 8'h0c;
    localparam logic [7:0] ADDR_LAST = 8'h3c;

    // Configuration word indices (word n at ADDR_CFG0 + 4n)
    localparam int CFG_N = 13;
    localparam int CFG_STSEL = 0;
    localparam int CFG_CTSEL = 2;
    localparam int CFG_DPISEL = 4;
    localparam int CFG_DPOSEL = 6;
    localparam int CFG_CLK = 7;
    localparam int CFG_REQ = 8;
    localparam int CFG_PORT = 9;
    localparam int CFG_SEG = 10;

    // Field positions inside configuration words
    localparam int SEL_STRIDE = 8;
    localparam int CLK_IDX_LSB = 0;
    localparam int CLK_MODE_LSB = 3;
    localparam int PORT_PIPE_LSB = 0;
    localparam int PORT_SYNC_LSB = 8;
    localparam int PORT_OEM_LSB = 16;

    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [31:0] CFG_RST = 32'h0000_0000;

    // Clock control modes per subcomponent
    typedef enum logic [1:0] {
        CLK_OFF = 2'b00,
        CLK_ON = 2'b01,
        CLK_GATE = 2'b10,
        CLK_GATE_N = 2'b11
    } ltrpi_clk_mode_t;

    // Output enable grouping of a port
    typedef enum logic [1:0] {
        OE_ALL = 2'b00,
        OE_HALF = 2'b01,
        OE_PAIR = 2'b10,
        OE_SINGLE = 2'b11
    } ltrpi_oe_mode_t;
endpackage

// [rtl/ltrpi_port.sv]
// One 8-bit I/O port: output pipeline, input synchroniser, grouped enables
`timescale 1ns/1ps
`default_nettype none
module ltrpi_port
    import ltrpi_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Routes from the tile routing
    input wire logic [PORT_W-1:0] i_dout,
    input wire logic [NDRV-1:0] i_drv,
    input wire logic [NOE-1:0] i_oe_route,
    // Configuration
    input wire logic [PORT_W-1:0] i_pipe,
    input wire logic [PORT_W-1:0] i_sync,
    input wire logic [1:0] i_oe_mode,
    // Pins
    input wire logic [PORT_W-1:0] i_pin_i,
    output logic [PORT_W-1:0] o_pin_o,
    output logic [PORT_W-1:0] o_pin_oe,
    output logic [NDRV-1:0] o_pin_drv,
    // Pin data back into the routing
    output logic [PORT_W-1:0] o_din
);
    logic [PORT_W-1:0] pipe_q;
    logic [PORT_W-1:0] sync1;
    logic [PORT_W-1:0] sync2;
    ltrpi_oe_mode_t oe_mode;

    assign oe_mode = ltrpi_oe_mode_t'(i_oe_mode);

    // Pipeline stage and two-stage synchroniser on the system clock
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            pipe_q <= '0;
            sync1 <= '0;
            sync2 <= '0;
            o_pin_drv <= '0;
        end
        else
        begin
            pipe_q <= i_dout;
            sync1 <= i_pin_i;
            sync2 <= sync1;
            o_pin_drv <= i_drv;
        end
    end

    // Per-pin selection; raw input is kept for combinational feed-through
    genvar p;
    generate
        for (p = 0; p < PORT_W; p++)
        begin : g_pin
            logic oe;
            always_comb
            begin
                unique case (oe_mode)
                    OE_ALL: oe = i_oe_route[0];
                    OE_HALF: oe = i_oe_route[p / 4];
                    OE_PAIR: oe = i_oe_route[p / 2];
                    // Modulo keeps the unused arm's index inside the vector
                    OE_SINGLE: oe = (p < NOE) ? i_oe_route[p % NOE] : 1'b0;
                endcase
            end
            assign o_pin_o[p] = i_pipe[p] ? pipe_q[p] : i_dout[p];
            assign o_pin_oe[p] = oe;
            assign o_din[p] = i_sync[p] ? sync2[p] : i_pin_i[p];
        end
    endgenerate

    property p_oe_off;
        @(posedge i_clk) disable iff (i_rst)
        (oe_mode == OE_ALL && !i_oe_route[0]) |-> (o_pin_oe == '0);
    endproperty
    a_oe_off: assert property (p_oe_off)
        else $error("pin driven while ganged enable is low");

    property p_pipe;
        @(posedge i_clk) disable iff (i_rst)
        (i_pipe[0] && $stable(i_pipe[0])) |-> o_pin_o[0] == $past(i_dout[0]);
    endproperty
    a_pipe: assert property (p_pipe)
        else $error("pipelined pin output not one cycle late");

    property p_sync;
        @(posedge i_clk) disable iff (i_rst)
        i_sync[0] ##0 i_sync[0] [*1] |-> o_din[0] == $past(i_pin_i[0], 2);
    endproperty
    a_sync: assert property (p_sync)
        else $error("synchronised pin input not two cycles late");
endmodule
`default_nettype wire

// [rtl/ltrpi_tap.sv]
// Registered one-of-N tap from a routing vector
`timescale 1ns/1ps
`default_nettype none
module ltrpi_tap
    import ltrpi_pkg::*;
#(
    parameter int N = 96,
    parameter int W = 7
)(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Source vector and wire index
    input wire logic [N-1:0] i_src,
    input wire logic [W-1:0] i_sel,
    // Selected wire, registered
    output logic o_bit
);
    logic next_bit;

    // An index beyond the vector reads as a quiet zero
    always_comb
    begin
        next_bit = 1'b0;
        if (int'(i_sel) < N)
            next_bit = i_src[i_sel];
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            o_bit <= 1'b0;
        else
            o_bit <= next_bit;
    end

    property p_tap_follow;
        @(posedge i_clk) disable iff (i_rst)
        (int'(i_sel) < N && i_src[i_sel]) |=> o_bit;
    endproperty
    a_tap_follow: assert property (p_tap_follow)
        else $error("tap did not follow selected wire");
endmodule
`default_nettype wire

// [rtl/ltrpi_top.sv]
// Top: APB status/control unit and routing-side connections of a logic tile
`timescale 1ns/1ps
`default_nettype none
module ltrpi_top
    import ltrpi_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Routing channel
    input wire logic [ROUTE_W-1:0] i_route,
    output logic [ROUTE_W-1:0] o_ctrl_route,
    output logic [ROUTE_W-1:0] o_seg_break,
    // Datapath connections
    output logic [DP_IN-1:0] o_dp_in,
    input wire logic [DP_COND-1:0] i_dp_cond,
    input wire logic [DP_SOUT-1:0] i_dp_sout,
    output logic [DP_OUT-1:0] o_dp_out,
    // Subcomponent clock enables
    output logic [NSUB-1:0] o_clk_en,
    // Interrupt and DMA requests
    output logic [1:0] o_irq_req,
    output logic [1:0] o_dma_req,
    // I/O port pins and pin data to routing
    input wire logic [PORT_W-1:0] i_pin_i,
    output logic [PORT_W-1:0] o_pin_o,
    output logic [PORT_W-1:0] o_pin_oe,
    output logic [NDRV-1:0] o_pin_drv,
    output logic [PORT_W-1:0] o_pin_din
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    logic [7:0] ctrl;
    logic [7:0] stmode;
    logic [7:0] stat;
    logic [31:0] cfg [CFG_N];
    logic [7:0] next_ctrl;
    logic [7:0] next_stmode;
    logic [7:0] next_stat;
    logic [31:0] next_cfg [CFG_N];
    logic [31:0] next_prdata;
    logic next_pslverr;
    logic [ROUTE_W-1:0] next_ctrl_route;
    logic [NSUB-1:0] next_clk_en;
    logic [NCTRL-1:0] st_tap;
    logic [NREQ-1:0] req_tap;
    logic [7:0] rd_clr;
    logic setup;
    logic access;
    logic bad_addr;
    logic [3:0] cfg_idx;
    logic [IDX_W-1:0] stsel [NCTRL];
    logic [IDX_W-1:0] ctsel [NCTRL];
    logic [2:0] clk_idx [NSUB];
    ltrpi_clk_mode_t clk_mode [NSUB];

    // APB phase decode; every access completes with no wait state
    assign setup = i_psel && !i_penable;
    assign access = i_psel && i_penable;
    assign bad_addr = (i_paddr[1:0] != 2'b00) || (i_paddr > ADDR_LAST);
    assign cfg_idx = 4'((i_paddr - ADDR_CFG0) >> 2);

    // Field decode of the configuration words
    genvar g;
    generate
        for (g = 0; g < NCTRL; g++)
        begin : g_sel
            assign stsel[g] = cfg[CFG_STSEL + g / 4][SEL_STRIDE * (g % 4) +:
                IDX_W];
            assign ctsel[g] = cfg[CFG_CTSEL + g / 4][SEL_STRIDE * (g % 4) +:
                IDX_W];
            // Status bit taps its own routing wire
            ltrpi_tap #(.N(ROUTE_W), .W(IDX_W)) u_st_tap (
                .i_clk(i_clk),
                .i_rst(i_rst),
                .i_src(i_route),
                .i_sel(stsel[g]),
                .o_bit(st_tap[g])
            );
        end
        for (g = 0; g < NSUB; g++)
        begin : g_clk
            assign clk_idx[g] = cfg[CFG_CLK][SEL_STRIDE * g + CLK_IDX_LSB +:
                3];
            assign clk_mode[g] = ltrpi_clk_mode_t'(
                cfg[CFG_CLK][SEL_STRIDE * g + CLK_MODE_LSB +: 2]);
        end
        // Six datapath inputs: [3:0] take their wire index from word CFG_DPISEL,
        // [5:4] from the word after it
        for (g = 0; g < DP_IN; g++)
        begin : g_dpi
            ltrpi_tap #(.N(ROUTE_W), .W(IDX_W)) u_dpi (
                .i_clk(i_clk),
                .i_rst(i_rst),
                .i_src(i_route),
                .i_sel(cfg[CFG_DPISEL + g / 4][SEL_STRIDE * (g % 4) +:
                    IDX_W]),
                .o_bit(o_dp_in[g])
            );
        end
        // Six datapath outputs from conditions or serial data out
        for (g = 0; g < DP_OUT; g++)
        begin : g_dpo
            ltrpi_tap #(.N(DP_SRC), .W(DP_SEL_W)) u_dpo (
                .i_clk(i_clk),
                .i_rst(i_rst),
                .i_src({i_dp_sout, i_dp_cond}),
                .i_sel(cfg[CFG_DPOSEL][DP_SEL_W * g +: DP_SEL_W]),
                .o_bit(o_dp_out[g])
            );
        end
        // Request taps may share one source wire freely
        for (g = 0; g < NREQ; g++)
        begin : g_req
            ltrpi_tap #(.N(ROUTE_W), .W(IDX_W)) u_req (
                .i_clk(i_clk),
                .i_rst(i_rst),
                .i_src(i_route),
                .i_sel(cfg[CFG_REQ][SEL_STRIDE * g +: IDX_W]),
                .o_bit(req_tap[g])
            );
        end
    endgenerate

    assign o_irq_req = req_tap[1:0];
    assign o_dma_req = req_tap[3:2];

    // Only the bits that a status read actually returned get cleared, so an
    // event between setup and access is not lost
    assign rd_clr = (access && !i_pwrite && i_paddr == ADDR_STATUS) ?
        o_prdata[7:0] : 8'h00;

    // Register writes in the access cycle; read data captured in the setup cycle
    always_comb
    begin
        next_ctrl = ctrl;
        next_stmode = stmode;
        next_cfg = cfg;
        next_prdata = 32'h0000_0000;
        next_pslverr = 1'b0;
        if (access && i_pwrite && !bad_addr)
        begin
            if (i_paddr == ADDR_CTRL)
                next_ctrl = i_pwdata[7:0];
            else if (i_paddr == ADDR_STMODE)
                next_stmode = i_pwdata[7:0];
            else if (i_paddr >= ADDR_CFG0)
                next_cfg[cfg_idx] = i_pwdata;
        end
        if (setup)
        begin
            next_pslverr = bad_addr;
            if (!bad_addr && !i_pwrite)
            begin
                if (i_paddr == ADDR_CTRL)
                    next_prdata = {24'h00_0000, ctrl};
                else if (i_paddr == ADDR_STATUS)
                    next_prdata = {24'h00_0000, stat};
                else if (i_paddr == ADDR_STMODE)
                    next_prdata = {24'h00_0000, stmode};
                else
                    next_prdata = cfg[cfg_idx];
            end
        end
    end

    // Status capture; a new event beats a clearing read
    always_comb
    begin
        next_stat = stat & ~rd_clr;
        if (o_clk_en[SUB_SC])
        begin
            for (int k = 0; k < NCTRL; k++)
            begin
                if (stmode[k])
                    next_stat[k] = next_stat[k] | st_tap[k];
                else
                    next_stat[k] = st_tap[k];
            end
        end
    end

    // Control bits placed onto their chosen routing wires
    always_comb
    begin
        next_ctrl_route = '0;
        for (int k = 0; k < NCTRL; k++)
        begin
            if (ctrl[k] && int'(ctsel[k]) < ROUTE_W)
                next_ctrl_route[ctsel[k]] = 1'b1;
        end
    end

    // Independent clock control per subcomponent
    always_comb
    begin
        for (int s = 0; s < NSUB; s++)
        begin
            unique case (clk_mode[s])
                CLK_OFF: next_clk_en[s] = 1'b0;
                CLK_ON: next_clk_en[s] = 1'b1;
                CLK_GATE: next_clk_en[s] = ctrl[clk_idx[s]];
                CLK_GATE_N: next_clk_en[s] = !ctrl[clk_idx[s]];
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            ctrl <= CTRL_RST;
            stmode <= CTRL_RST;
            stat <= CTRL_RST;
            for (int i = 0; i < CFG_N; i++)
                cfg[i] <= CFG_RST;
            o_prdata <= 32'h0000_0000;
            o_pslverr <= 1'b0;
            o_pready <= 1'b1;
            o_ctrl_route <= '0;
            o_seg_break <= '0;
            o_clk_en <= '0;
        end
        else
        begin
            ctrl <= next_ctrl;
            stmode <= next_stmode;
            stat <= next_stat;
            cfg <= next_cfg;
            o_prdata <= next_prdata;
            o_pslverr <= next_pslverr;
            o_pready <= 1'b1;
            o_ctrl_route <= next_ctrl_route;
            // 96-wire channel, one break bit per wire
            o_seg_break <= {cfg[CFG_SEG + 2], cfg[CFG_SEG + 1],
                cfg[CFG_SEG]};
            o_clk_en <= next_clk_en;
        end
    end

    // The single I/O port fed from routing
    ltrpi_port u_port (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_dout(i_route[PORT_OUT_LSB +: PORT_W]),
        .i_drv(i_route[PORT_DRV_LSB +: NDRV]),
        .i_oe_route(i_route[PORT_OE_LSB +: NOE]),
        .i_pipe(cfg[CFG_PORT][PORT_PIPE_LSB +: PORT_W]),
        .i_sync(cfg[CFG_PORT][PORT_SYNC_LSB +: PORT_W]),
        .i_oe_mode(cfg[CFG_PORT][PORT_OEM_LSB +: 2]),
        .i_pin_i(i_pin_i),
        .o_pin_o(o_pin_o),
        .o_pin_oe(o_pin_oe),
        .o_pin_drv(o_pin_drv),
        .o_din(o_pin_din)
    );

    property p_ctrl_wr;
        (access && i_pwrite && i_paddr == ADDR_CTRL) |=>
            ctrl == $past(i_pwdata[7:0]);
    endproperty
    a_ctrl_wr: assert property (p_ctrl_wr)
        else $error("control write not stored");

    property p_ctrl_route;
        (ctrl[0] && int'(ctsel[0]) < ROUTE_W) |=> o_ctrl_route[$past(ctsel[0])];
    endproperty
    a_ctrl_route: assert property (p_ctrl_route)
        else $error("control bit missing on its routing wire");

    property p_sticky;
        (stmode[0] && stat[0] && !rd_clr[0]) |=> stat[0];
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("sticky status lost without a read");

    property p_set_wins;
        (stmode[0] && st_tap[0] && o_clk_en[SUB_SC]) |=> stat[0];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("status event lost on clearing read");

    property p_clk_off;
        (clk_mode[SUB_PLD0] == CLK_OFF) |=> !o_clk_en[SUB_PLD0];
    endproperty
    a_clk_off: assert property (p_clk_off)
        else $error("disabled subcomponent clock enabled");

    property p_clk_gate;
        (clk_mode[SUB_DP] == CLK_GATE && ctrl[clk_idx[SUB_DP]]) |=>
            o_clk_en[SUB_DP];
    endproperty
    a_clk_gate: assert property (p_clk_gate)
        else $error("control bit did not enable datapath clock");

    c_status_clear: cover property (rd_clr != 8'h00 ##1 stat == 8'h00);
    c_ctrl_write: cover property (access && i_pwrite && i_paddr == ADDR_CTRL);
    c_clk_gate: cover property (clk_mode[SUB_DP] == CLK_GATE ##1
        o_clk_en[SUB_DP]);
endmodule
`default_nettype wire

// [verif/ltrpi_pad_model.sv]
// Pad model: resolves each I/O pin from the port driver and the outside
`timescale 1ns/1ps
`default_nettype none
module ltrpi_pad_model
    import ltrpi_pkg::*;
(
    // Clock
    input wire logic i_clk,
    // Port driver side
    input wire logic [PORT_W-1:0] i_pin_o,
    input wire logic [PORT_W-1:0] i_pin_oe,
    // Outside driver, used only where the port lets go
    input wire logic [PORT_W-1:0] i_ext_en,
    input wire logic [PORT_W-1:0] i_ext_val,
    // Resolved pad level seen by the port input
    output logic [PORT_W-1:0] o_pad
);
    logic [PORT_W-1:0] last;

    // Port wins while enabled; a floating pad toggles so no stale value shows
    assign o_pad = (i_pin_oe & i_pin_o)
        | (~i_pin_oe & i_ext_en & i_ext_val)
        | (~i_pin_oe & ~i_ext_en & ~last);

    // Last level, only to make the float pattern move every cycle
    always_ff @(posedge i_clk)
    begin
        last <= o_pad;
    end
endmodule
`default_nettype wire

// [verif/testbench.sv]
// Self-checking bench: APB sequences against routing, datapath and pins
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) \
    begin \
        tests_run++; \
        if ((g) !== (e)) \
        begin \
            bad_count++; \
            $display("mismatch %s exp %h got %h", nm, e, g); \
        end \
    end
module testbench
    import ltrpi_pkg::*;
;
    logic clk, rst, psel, pen, pwr, pready, pslverr;
    logic [7:0] paddr, dp_cond, pin_i, pin_o, pin_oe, pin_din;
    logic [7:0] ext_en, ext_val;
    logic [31:0] pwdata, prdata, rdat;
    logic rerr;
    logic [95:0] route, ctrl_route, seg;
    logic [5:0] dp_in, dp_out;
    logic [1:0] dp_sout, irq, dma;
    logic [3:0] clk_en, pin_drv;
    int tests_run = 0;
    int bad_count = 0;
    // Expected enables per grouping mode with only route enable 0 high
    localparam logic [7:0] OE_EXP [4] = '{8'hff, 8'h0f, 8'h03, 8'h01};

    ltrpi_top ltrpi_top_i (.i_clk(clk), .i_rst(rst), .i_psel(psel),
        .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_route(route), .o_ctrl_route(ctrl_route),
        .o_seg_break(seg), .o_dp_in(dp_in), .i_dp_cond(dp_cond),
        .i_dp_sout(dp_sout), .o_dp_out(dp_out), .o_clk_en(clk_en),
        .o_irq_req(irq), .o_dma_req(dma), .i_pin_i(pin_i),
        .o_pin_o(pin_o), .o_pin_oe(pin_oe), .o_pin_drv(pin_drv),
        .o_pin_din(pin_din));

    ltrpi_pad_model ltrpi_pad_model_i (.i_clk(clk), .i_pin_o(pin_o),
        .i_pin_oe(pin_oe), .i_ext_en(ext_en), .i_ext_val(ext_val),
        .o_pad(pin_i));

    // Free-running 100 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic summarize();
        $display("tests %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // One APB transfer; the leading edge keeps drives one per time step
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
        begin
            n++;
            if (n > 16)
            begin
                bad_count++;
                summarize();
            end
            @(posedge clk);
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask

    task automatic cfg(input int n, input logic [31:0] d);
        apb(1'b1, ADDR_CFG0 + 8'(4 * n), d);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Main sequence
    initial
    begin
        {psel, pen, pwr, paddr, pwdata} = '0;
        {route, dp_cond, dp_sout} = '0;
        ext_en = 8'hff;
        ext_val = 8'h00;
        rst = 1'b1;
        idle(3);
        rst <= 1'b0;
        for (int a = 0; a <= 8'h3c; a += 4)
        begin
            rd(8'(a));
            `CHK("reset word", 32'h0, rdat)
        end
        `CHK("reset ctrl route", 96'h0, ctrl_route)
        $display("test reset done");

        cfg(CFG_CTSEL, 32'h0000_0128);
        cfg(CFG_CLK, 32'h0810_0819);
        apb(1'b1, ADDR_CTRL, 32'h1);
        idle(2);
        `CHK("ctrl wire 40", 1'b1, ctrl_route[40])
        `CHK("ctrl wire 1", 1'b0, ctrl_route[1])
        `CHK("clk en a", 4'hf, clk_en)
        apb(1'b1, ADDR_CTRL, 32'h2);
        idle(2);
        `CHK("ctrl pair", 2'b01, {ctrl_route[40], ctrl_route[1]})
        `CHK("clk en b", 4'ha, clk_en)
        rd(ADDR_CTRL);
        `CHK("ctrl read", 32'h2, rdat)
        $display("test control done");

        cfg(CFG_STSEL, 32'h0000_0b0a);
        route[10] <= 1'b1;
        idle(3);
        rd(ADDR_STATUS);
        `CHK("status live", 32'h1, rdat)
        apb(1'b1, ADDR_STATUS, 32'hff);
        `CHK("status wr err", 1'b0, rerr)
        route[10] <= 1'b0;
        idle(3);
        rd(ADDR_STATUS);
        `CHK("status ro", 32'h0, rdat)
        apb(1'b1, ADDR_STMODE, 32'h3);
        route[11:10] <= 2'b11;
        idle(1);
        route[11:10] <= 2'b00;
        idle(3);
        rd(ADDR_STATUS);
        `CHK("sticky held", 32'h3, rdat)
        rd(ADDR_STATUS);
        `CHK("sticky clear", 32'h0, rdat)
        // Wire held high, so each clearing read meets a fresh event
        route[10] <= 1'b1;
        idle(3);
        rd(ADDR_STATUS);
        `CHK("set before clear", 32'h1, rdat)
        rd(ADDR_STATUS);
        `CHK("set wins", 32'h1, rdat)
        route[10] <= 1'b0;
        rd(8'h40);
        `CHK("unmapped err", 1'b1, rerr)
        `CHK("unmapped data", 32'h0, rdat)
        rd(8'h06);
        `CHK("unaligned err", 1'b1, rerr)
        $display("test status done");

        cfg(CFG_DPISEL, 32'h1716_1514);
        cfg(CFG_DPISEL + 1, 32'h0000_1918);
        cfg(CFG_DPOSEL, 32'h0000_0938);
        route[25:20] <= 6'b100101;
        dp_sout <= 2'b01;
        dp_cond <= 8'h08;
        idle(2);
        `CHK("dp in", 6'b100101, dp_in)
        `CHK("dp out", 6'b000011, dp_out)
        cfg(CFG_REQ, 32'h1f1e_1f1e);
        route[30] <= 1'b1;
        idle(2);
        `CHK("irq", 2'b01, irq)
        `CHK("dma", 2'b01, dma)
        cfg(CFG_SEG + 2, 32'h8000_0001);
        idle(2);
        `CHK("seg", 96'h8000_0001_0000_0000_0000_0000, seg)
        $display("test datapath done");

        cfg(CFG_PORT, 32'h0003_0101);
        route[15:0] <= 16'h1a01;
        // Pipe stage, then two synchroniser stages, before the pin reads back
        idle(4);
        `CHK("oe single", 8'h01, pin_oe)
        `CHK("drive", 4'ha, pin_drv)
        `CHK("pipe out", 1'b1, pin_o[0])
        `CHK("sync in", 1'b1, pin_din[0])
        route[12] <= 1'b0;
        idle(3);
        `CHK("oe off", 8'h00, pin_oe)
        `CHK("ext in", 1'b0, pin_din[0])
        route[12] <= 1'b1;
        for (int m = 0; m < 4; m++)
        begin
            cfg(CFG_PORT, 32'(m) << PORT_OEM_LSB);
            idle(1);
            `CHK("oe group", OE_EXP[m], pin_oe)
        end
        $display("test pins done");
        summarize();
    end
endmodule
`undef CHK
`default_nettype wire
